// ==== verilog/fws_host.sv ====
// Host controller running flash status polling over AHB-Lite registers
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module fws_host import fws_pkg::*; (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Flash pins
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [DQ_W-1:0]        fl_dq_o,
  output logic                   fl_dq_oe,
  input  wire logic [DQ_W-1:0]   fl_dq_i
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_WRITE, ST_READ, ST_DP_READ, ST_DP_RECHK, ST_DP_FINAL,
    ST_TG_A, ST_TG_B, ST_TG_C, ST_TG_D, ST_TG_FINAL, ST_RST_CMD
  } fws_state_e;

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Bus slave state
  logic              wr_pend_q, wr_pend_d;
  logic [REG_AW-1:0] wr_addr_q, wr_addr_d;
  logic [31:0]       hrdata_q, hrdata_d;
  logic              acc;

  // Controller state
  fws_state_e        st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DQ_W-1:0]   wdata_q, wdata_d;
  logic              use_tb2_q, use_tb2_d;
  logic              done_q, done_d;
  logic              fail_q, fail_d;
  logic [DQ_W-1:0]   last_q, last_d;
  logic [DQ_W-1:0]   tb_first_q, tb_first_d;
  logic              start_q, start_d;
  fws_cyc_s          cyc_q, cyc_d;

  logic              busy;
  logic              cyc_done;
  logic [DQ_W-1:0]   cyc_rdata;
  fws_pin_s          pins;
  logic [DQ_W-1:0]   tb_mask;
  logic              tb_eq;
  logic              poll_ok;
  logic              go;
  fws_op_e           go_op;
  logic [31:0]       stat_word;
  fws_cyc_s          rd_req;

  assign busy    = (st_q != ST_IDLE);
  assign acc     = hsel && hready && htrans[HTRANS_ACT_BIT]
                   && (hsize == HSIZE_WORD);
  assign tb_mask = use_tb2_q ? (MASK_TB1 | MASK_TB2) : MASK_TB1;
  assign tb_eq   = (((cyc_rdata ^ tb_first_q) & tb_mask) == '0);
  assign poll_ok = (cyc_rdata[POLL_BIT] == wdata_q[POLL_BIT]);
  assign go      = wr_pend_q && (wr_addr_q == REG_CTRL) && !busy;
  assign go_op   = fws_op_e'(hwdata[CTRL_OP_MSB:0]);
  assign rd_req  = '{wr: 1'b0, addr: addr_q, wdata: wdata_q};
  assign stat_word = {16'h0000, last_q, 3'h0, last_q[TOF_BIT],
                      last_q[WIN_BIT], fail_q, done_q, busy};

  always_comb begin
    wr_pend_d = acc && hwrite;
    wr_addr_d = acc ? haddr[REG_AW-1:0] : wr_addr_q;
    hrdata_d  = hrdata_q;
    if (acc && !hwrite) begin
      unique case (haddr[REG_AW-1:0])
        REG_CTRL:   hrdata_d = {28'h000_0000, use_tb2_q, 3'h0};
        REG_ADDR:   hrdata_d = {13'h0000, addr_q};
        REG_WDATA:  hrdata_d = {24'h00_0000, wdata_q};
        REG_STATUS: hrdata_d = stat_word;
        REG_RDATA:  hrdata_d = {24'h00_0000, last_q};
        default:    hrdata_d = '0;
      endcase
    end
  end

  always_comb begin
    st_d       = st_q;
    addr_d     = addr_q;
    wdata_d    = wdata_q;
    use_tb2_d  = use_tb2_q;
    done_d     = done_q;
    fail_d     = fail_q;
    last_d     = last_q;
    tb_first_d = tb_first_q;
    start_d    = 1'b0;
    cyc_d      = cyc_q;
    // Poll address and data frozen while busy so every status read
    // targets the same location
    if (wr_pend_q && !busy && (wr_addr_q == REG_ADDR)) begin
      addr_d = hwdata[ADDR_W-1:0];
    end
    if (wr_pend_q && !busy && (wr_addr_q == REG_WDATA)) begin
      wdata_d = hwdata[DQ_W-1:0];
    end
    if (cyc_done && !cyc_q.wr) begin
      last_d = cyc_rdata;
    end
    unique case (st_q)
      ST_IDLE: begin
        if (go && (go_op != OP_NONE)) begin
          done_d    = 1'b0;
          fail_d    = 1'b0;
          use_tb2_d = hwdata[CTRL_TB2_BIT];
          start_d   = 1'b1;
          cyc_d     = rd_req;
          unique case (go_op)
            OP_WRITE: begin
              cyc_d.wr = 1'b1;
              st_d     = ST_WRITE;
            end
            OP_READ:        st_d = ST_READ;
            OP_DATA_POLL:   st_d = ST_DP_READ;
            OP_TOGGLE_POLL: st_d = ST_TG_A;
            OP_RESET: begin
              cyc_d = '{wr: 1'b1, addr: addr_q, wdata: RESET_CMD};
              st_d  = ST_RST_CMD;
            end
            default: begin
              start_d = 1'b0;
              st_d    = ST_IDLE;
            end
          endcase
        end
      end
      ST_WRITE, ST_READ, ST_DP_FINAL, ST_TG_FINAL, ST_RST_CMD: begin
        if (cyc_done) begin
          done_d = 1'b1;
          st_d   = ST_IDLE;
        end
      end
      ST_DP_READ, ST_DP_RECHK: begin
        if (cyc_done) begin
          start_d = 1'b1;
          if (poll_ok) begin
            st_d = ST_DP_FINAL;
          end else if (st_q == ST_DP_READ && cyc_rdata[TOF_BIT]) begin
            st_d = ST_DP_RECHK;
          end else if (st_q == ST_DP_READ) begin
            st_d = ST_DP_READ;
          end else begin
            fail_d = 1'b1;
            cyc_d  = '{wr: 1'b1, addr: addr_q, wdata: RESET_CMD};
            st_d   = ST_RST_CMD;
          end
        end
      end
      ST_TG_A, ST_TG_C: begin
        if (cyc_done) begin
          tb_first_d = cyc_rdata;
          start_d    = 1'b1;
          st_d       = (st_q == ST_TG_A) ? ST_TG_B : ST_TG_D;
        end
      end
      ST_TG_B, ST_TG_D: begin
        if (cyc_done) begin
          start_d = 1'b1;
          if (tb_eq) begin
            st_d = ST_TG_FINAL;
          end else if (st_q == ST_TG_B && cyc_rdata[TOF_BIT]) begin
            st_d = ST_TG_C;
          end else if (st_q == ST_TG_B) begin
            st_d = ST_TG_A;
          end else begin
            fail_d = 1'b1;
            cyc_d  = '{wr: 1'b1, addr: addr_q, wdata: RESET_CMD};
            st_d   = ST_RST_CMD;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= '0;
      hrdata_q   <= '0;
      st_q       <= ST_IDLE;
      addr_q     <= '0;
      wdata_q    <= '0;
      use_tb2_q  <= 1'b0;
      done_q     <= 1'b0;
      fail_q     <= 1'b0;
      last_q     <= '0;
      tb_first_q <= '0;
      start_q    <= 1'b0;
      cyc_q      <= CYC_IDLE;
    end else begin
      wr_pend_q  <= wr_pend_d;
      wr_addr_q  <= wr_addr_d;
      hrdata_q   <= hrdata_d;
      st_q       <= st_d;
      addr_q     <= addr_d;
      wdata_q    <= wdata_d;
      use_tb2_q  <= use_tb2_d;
      done_q     <= done_d;
      fail_q     <= fail_d;
      last_q     <= last_d;
      tb_first_q <= tb_first_d;
      start_q    <= start_d;
      cyc_q      <= cyc_d;
    end
  end

  // Zero-wait slave: hreadyout and hresp are constant flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  assign hrdata = hrdata_q;

  fws_bus_cycle u_cycle (
    .clk   (core_clk),
    .rst_n (rst_n),
    .start (start_q),
    .req   (cyc_q),
    .done  (cyc_done),
    .rdata (cyc_rdata),
    .pins  (pins),
    .dq_i  (fl_dq_i)
  );

  assign fl_ce_n  = pins.ce_n;
  assign fl_oe_n  = pins.oe_n;
  assign fl_we_n  = pins.we_n;
  assign fl_addr  = pins.addr;
  assign fl_dq_o  = pins.dq_o;
  assign fl_dq_oe = pins.dq_oe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_POLL_ADDR: assert property (
    (busy && $fell(fl_oe_n)) |-> (fl_addr == addr_q))
    else $error("status read not at the poll address");
  AST_FULL_BYTE: assert property (
    (st_q == ST_DP_READ && cyc_done && poll_ok)
      |=> (st_q == ST_DP_FINAL && start_q ##1 !fl_ce_n))
    else $error("no fresh read after poll bit turned true");
  AST_DOUBLE_READ: assert property (
    (st_q == ST_TG_B && cyc_done && tb_eq) |=> (st_q == ST_TG_FINAL))
    else $error("equal toggle reads did not end polling");
  AST_RECHECK: assert property (
    (st_q == ST_TG_B && cyc_done && !tb_eq && cyc_rdata[TOF_BIT])
      |=> (st_q == ST_TG_C) ##[1:20] (st_q == ST_TG_D))
    else $error("timeout bit high without two more reads");
  AST_TG_FAIL: assert property (
    (st_q == ST_TG_D && cyc_done && !tb_eq)
      |=> (st_q == ST_RST_CMD && fail_q && start_q))
    else $error("persistent toggling not flagged as failure");
  AST_RESTART: assert property (
    (st_q == ST_TG_B && cyc_done && !tb_eq && !cyc_rdata[TOF_BIT])
      |=> (st_q == ST_TG_A) ##[1:20] (st_q == ST_TG_B))
    else $error("toggle detection not restarted with a double read");
  AST_RST_CMD: assert property (
    (st_q == ST_RST_CMD && start_q) |-> (cyc_q.wr && cyc_q.wdata == RESET_CMD))
    else $error("reset cycle without the reset command");
  AST_F0_SINGLE: assert property (
    (st_q == ST_RST_CMD && $rose(fl_we_n))
      |-> ##[1:3] (st_q == ST_IDLE && done_q))
    else $error("reset command not a single write cycle");
  AST_F0_PIN: assert property (
    (st_q == ST_RST_CMD && $fell(fl_we_n))
      |-> (fl_dq_oe && fl_dq_o == RESET_CMD))
    else $error("reset write not driving F0");
  AST_WIN_BIT: assert property (
    (busy && cyc_done && !cyc_q.wr)
      |=> (stat_word[WIN_BIT] == $past(cyc_rdata[WIN_BIT])))
    else $error("erase window bit not reported from last read");

  COV_WRITE: cover property ((st_q == ST_WRITE) ##1 (st_q == ST_IDLE));
  COV_TG_OK: cover property ((st_q == ST_TG_FINAL) ##1 (st_q == ST_IDLE));
  COV_TG_FAIL: cover property ((st_q == ST_TG_D) ##1 (st_q == ST_RST_CMD));
  COV_DP_OK: cover property ((st_q == ST_DP_FINAL) ##1 (st_q == ST_IDLE));

endmodule

`default_nettype wire

// ==== verilog/fws_pkg.sv ====
// Shared constants and types for the flash write-status host controller
package fws_pkg;

  // Timing at core_clk
  localparam int T_CLK_NS    = 40;
  localparam int T_ACC_NS    = 90;
  localparam int T_WP_NS     = 45;
  localparam int SYNC_STAGES = 2;
  localparam int ACC_CYC     = (T_ACC_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int WP_CYC      = (T_WP_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int CNT_W       = 3;
  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(ACC_CYC + SYNC_STAGES - 1);
  localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WP_CYC - 1);

  // Flash pin widths
  localparam int ADDR_W = 19;
  localparam int DQ_W   = 8;

  // Status byte bit positions
  localparam int POLL_BIT = 7;
  localparam int TB1_BIT  = 6;
  localparam int TOF_BIT  = 5;
  localparam int WIN_BIT  = 3;
  localparam int TB2_BIT  = 2;
  localparam logic [DQ_W-1:0] MASK_TB1  = 8'h40;
  localparam logic [DQ_W-1:0] MASK_TB2  = 8'h04;
  localparam logic [DQ_W-1:0] RESET_CMD = 8'hF0;

  // Register map, byte addresses
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [REG_AW-1:0] REG_ADDR   = 8'h04;
  localparam logic [REG_AW-1:0] REG_WDATA  = 8'h08;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h0C;
  localparam logic [REG_AW-1:0] REG_RDATA  = 8'h10;

  // Control register fields
  localparam int CTRL_OP_MSB  = 2;
  localparam int CTRL_TB2_BIT = 3;

  // AHB
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACT_BIT = 1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_WRITE,
    OP_READ,
    OP_DATA_POLL,
    OP_TOGGLE_POLL,
    OP_RESET
  } fws_op_e;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   wdata;
  } fws_cyc_s;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq_o;
    logic              dq_oe;
  } fws_pin_s;

  localparam fws_pin_s PIN_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                    addr: '0, dq_o: '0, dq_oe: 1'b0};
  localparam fws_cyc_s CYC_IDLE = '{wr: 1'b0, addr: '0, wdata: '0};

endpackage

// ==== verilog/fws_bus_cycle.sv ====
// One flash read or write cycle on the parallel pins
`timescale 1ns/1ps
`default_nettype none

module fws_bus_cycle import fws_pkg::*; (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Cycle request
  input  wire logic            start,
  input  wire fws_cyc_s        req,
  // Cycle result
  output logic                 done,
  output logic [DQ_W-1:0]      rdata,
  // Flash pins
  output var fws_pin_s         pins,
  input  wire logic [DQ_W-1:0] dq_i
);

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_RECOVER} fws_bc_e;

  fws_bc_e          st_q, st_d;
  fws_pin_s         pins_q, pins_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             wr_q, wr_d;
  logic             done_q, done_d;
  logic [DQ_W-1:0]  rdata_q, rdata_d;
  logic [DQ_W-1:0]  dq_s1_q, dq_s2_q;

  always_comb begin
    st_d    = st_q;
    pins_d  = pins_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    done_d  = 1'b0;
    rdata_d = rdata_q;
    unique case (st_q)
      BC_IDLE: begin
        if (start) begin
          wr_d         = req.wr;
          pins_d.ce_n  = 1'b0;
          pins_d.addr  = req.addr;
          pins_d.dq_o  = req.wdata;
          pins_d.dq_oe = req.wr;
          st_d         = BC_SETUP;
        end
      end
      BC_SETUP: begin
        // One cycle of address setup before the strobe falls
        if (wr_q) begin
          pins_d.we_n = 1'b0;
          cnt_d       = WR_CNT;
        end else begin
          pins_d.oe_n = 1'b0;
          cnt_d       = RD_CNT;
        end
        st_d = BC_STROBE;
      end
      BC_STROBE: begin
        if (cnt_q == '0) begin
          // Read strobe covers access time plus the synchroniser delay
          if (!wr_q) begin
            rdata_d = dq_s2_q;
          end
          pins_d.oe_n = 1'b1;
          pins_d.we_n = 1'b1;
          st_d        = BC_RECOVER;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      BC_RECOVER: begin
        // Data held one cycle past the rising write strobe
        pins_d = PIN_IDLE;
        done_d = 1'b1;
        st_d   = BC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= BC_IDLE;
      pins_q  <= PIN_IDLE;
      cnt_q   <= '0;
      wr_q    <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= '0;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      st_q    <= st_d;
      pins_q  <= pins_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  assign pins  = pins_q;
  assign done  = done_q;
  assign rdata = rdata_q;

endmodule

`default_nettype wire

// ==== tb/fws_flash_model.sv ====
// Behavioural flash device answering status reads from the host controller
`timescale 1ns/1ps
`default_nettype none

module fws_flash_model import fws_pkg::*; (
  // Flash pins
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DQ_W-1:0]   dq_i,
  output logic [DQ_W-1:0]        dq_o,
  // Scenario control
  input  wire logic              load,
  input  wire logic [1:0]        ld_mode,
  input  wire logic [7:0]        ld_left,
  input  wire logic [DQ_W-1:0]   ld_byte,
  input  wire logic              ld_fail,
  input  wire logic              ld_win,
  input  wire logic              ld_prot,
  // Observation
  output logic [15:0]            reads,
  output logic [DQ_W-1:0]        wr_byte,
  output logic [ADDR_W-1:0]      wr_addr
);
  localparam logic [1:0] M_PROG  = 2'h1;
  localparam logic [1:0] M_ERASE = 2'h2;
  localparam logic [1:0] M_SUSP  = 2'h3;
  logic [1:0]      mode;
  logic [7:0]      left;
  logic [DQ_W-1:0] pd, arr, last, stat;
  logic            fail, win, tb1, tb2, rd_act, busy, prot;

  assign rd_act = !ce_n && !oe_n && we_n;
  assign busy   = (mode == M_PROG) || (mode == M_ERASE);
  initial begin
    mode = 2'h0;
    tb1  = 1'b0;
    tb2  = 1'b0;
    last = 8'h00;
  end

  always @* begin
    case (mode)
      M_PROG:  stat = {~pd[7], tb1, fail, 5'h00};
      M_ERASE: stat = {1'b0, tb1, fail, 1'b0, win, tb2, 2'h0};
      M_SUSP:  stat = {1'b1, tb1, 1'b0, 2'h0, tb2, 2'h0};
      default: stat = arr;
    endcase
    // No pull-up on the data lines, so a released bus shows the inverse
    dq_o = rd_act ? stat : ~last;
  end

  always @(negedge rd_act) begin
    last  = stat;
    reads = reads + 16'h0001;
    if (busy) tb1 = ~tb1;
    if (mode == M_ERASE || mode == M_SUSP) tb2 = ~tb2;
    if (busy && !fail) begin
      if (left <= 8'h01) begin
        // A protected target keeps its old contents
        if (!prot) arr = (mode == M_PROG) ? pd : 8'hFF;
        mode = 2'h0;
      end
      left = left - 8'h01;
    end
  end

  always @(posedge we_n) begin
    if (!ce_n) begin
      wr_byte = dq_i;
      wr_addr = addr;
      if (dq_i == RESET_CMD && !(mode == M_ERASE && win && !fail)) begin
        mode = 2'h0;
        fail = 1'b0;
      end
    end
  end

  // A load stands for the final write strobe of a command sequence
  always @(posedge load) begin
    mode  = ld_mode;
    left  = ld_left;
    pd    = ld_byte;
    prot  = ld_prot;
    if (!ld_prot) arr = ld_byte;
    fail  = ld_fail;
    win   = ld_win;
    reads = 16'h0000;
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the flash status host controller
`timescale 1ns/1ps
`default_nettype none

module tb_top import fws_pkg::*;;
  localparam logic [1:0] M_PROG  = 2'h1;
  localparam logic [1:0] M_ERASE = 2'h2;
  localparam logic [1:0] M_SUSP  = 2'h3;
  logic              core_clk, nrst, hsel, hwrite, hreadyout, hresp, load;
  logic [31:0]       haddr, hwdata, hrdata, rd, st;
  logic [1:0]        htrans, ld_mode, m;
  logic [2:0]        hsize;
  logic              fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, ld_fail, ld_win;
  logic              ld_prot;
  logic [ADDR_W-1:0] fl_addr, wr_addr, a19;
  logic [DQ_W-1:0]   fl_dq_o, fl_dq_i, mdl_dq, ld_byte, wr_byte, b;
  logic [7:0]        ld_left, n;
  logic [15:0]       reads;
  integer            bad_count, checks, cyc, seed, i;

  assign fl_dq_i = fl_dq_oe ? fl_dq_o : mdl_dq;

  fws_host dut (
    .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i)
  );

  fws_flash_model flash (
    .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .addr(fl_addr),
    .dq_i(fl_dq_i), .dq_o(mdl_dq), .load(load), .ld_mode(ld_mode),
    .ld_left(ld_left), .ld_byte(ld_byte), .ld_fail(ld_fail),
    .ld_win(ld_win), .ld_prot(ld_prot), .reads(reads),
    .wr_byte(wr_byte), .wr_addr(wr_addr)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A stuck poll loop never raises done, so the cycle ceiling ends it
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, want);
    checks = checks + 1;
    if (seen !== want) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic setup(input logic [1:0] md, input logic [7:0] cnt,
                       input logic [7:0] byt, input logic f, w);
    ld_mode <= md;
    ld_left <= cnt;
    ld_byte <= byt;
    ld_fail <= f;
    ld_win  <= w;
    load    <= 1'b1;
    @(posedge core_clk);
    load    <= 1'b0;
  endtask

  task automatic run_op(input logic [31:0] ctrl);
    integer k;
    ahb(1'b1, REG_CTRL, ctrl, rd);
    ahb(1'b0, REG_STATUS, 32'h0000_0000, st);
    chk("busy after start", st & 32'h0000_0001, 32'h0000_0001);
    k = 0;
    while (st[0] === 1'b1 && k < 1500) begin
      ahb(1'b0, REG_STATUS, 32'h0000_0000, st);
      k = k + 1;
    end
    chk("done flag", st & 32'h0000_0003, 32'h0000_0002);
    ahb(1'b0, REG_RDATA, 32'h0000_0000, rd);
  endtask

  function automatic logic [31:0] final_byte(input logic [1:0] md,
                                             input logic [7:0] byt);
    return {24'h00_0000, (md == M_PROG) ? byt : 8'hFF};
  endfunction

  // Status reads until the array returns, then the match and one extra read
  function automatic logic [15:0] poll_reads(input logic [7:0] cnt);
    return {8'h00, cnt} + 16'h0002;
  endfunction

  initial begin
    seed = 44982;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0000_0000;
    load = 1'b0;
    ld_mode = 2'h0;
    ld_left = 8'h00;
    ld_byte = 8'h00;
    ld_fail = 1'b0;
    ld_win = 1'b0;
    ld_prot = 1'b0;
    repeat (3) @(posedge core_clk);
    chk("ce_n in reset", fl_ce_n, 1'b1);
    chk("dq_oe in reset", fl_dq_oe, 1'b0);
    chk("oe_n in reset", fl_oe_n, 1'b1);
    chk("we_n in reset", fl_we_n, 1'b1);
    chk("hresp okay", hresp, 1'b0);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    ahb(1'b0, REG_STATUS, 32'h0000_0000, st);
    chk("status after reset", st, 32'h0000_0000);
    ahb(1'b1, 8'h14, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 8'h14, 32'h0000_0000, rd);
    chk("unmapped read", rd, 32'h0000_0000);
    ahb(1'b1, REG_CTRL, 32'h0000_0008, rd);
    ahb(1'b0, REG_CTRL, 32'h0000_0000, rd);
    // A control write with no operation leaves the stored field alone
    chk("ctrl readback", rd, 32'h0000_0000);
    setup(2'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    b = $random(seed);
    a19 = $random(seed);
    ahb(1'b1, REG_ADDR, {13'h0000, a19}, rd);
    ahb(1'b1, REG_WDATA, {24'h00_0000, b}, rd);
    run_op(32'h0000_0001);
    chk("written byte", wr_byte, b);
    chk("written address", wr_addr, a19);
    run_op(32'h0000_0005);
    chk("reset op byte", wr_byte, RESET_CMD);
    chk("reset op address", wr_addr, a19);
    for (i = 0; i < 2; i++) begin
      setup(M_ERASE, 8'h32, 8'hFF, 1'b0, i[0]);
      run_op(32'h0000_0002);
      chk("poll bit in erase", rd[7], 1'b0);
      chk("window bit read", rd[3], i[0]);
      chk("window bit status", st[3], i[0]);
      chk("timeout bit clear", st[4], 1'b0);
    end
    for (i = 0; i < 8; i++) begin
      m = i[0] ? M_ERASE : M_PROG;
      b = $random(seed);
      n = 8'h01 + ($random(seed) & 8'h07);
      setup(m, n, b, 1'b0, 1'b0);
      ahb(1'b1, REG_WDATA, final_byte(m, b), rd);
      run_op(i[1] ? {28'h000_0000, i[2], 3'h4} : 32'h0000_0003);
      chk("array byte after poll", rd, final_byte(m, b));
      chk("no failure", st[2], 1'b0);
      if (!i[1]) chk("poll read count", reads, poll_reads(n));
    end
    // Last pass above started a toggle poll with the second bit enabled
    ahb(1'b0, REG_CTRL, 32'h0000_0000, rd);
    chk("ctrl tb2 kept", rd, 32'h0000_0008);
    for (i = 0; i < 2; i++) begin
      setup(M_PROG, 8'hFF, 8'h00, 1'b1, 1'b0);
      ahb(1'b1, REG_WDATA, 32'h0000_0000, rd);
      run_op(i[0] ? 32'h0000_0004 : 32'h0000_0003);
      chk("fail flag", st[2], 1'b1);
      chk("timeout bit seen", st[4], 1'b1);
      chk("reset command", wr_byte, RESET_CMD);
      chk("fail read count", reads, i[0] ? 16'h0004 : 16'h0002);
    end
    for (i = 0; i < 2; i++) begin
      setup(M_SUSP, 8'h00, 8'h00, 1'b0, 1'b0);
      ahb(1'b1, REG_WDATA, 32'h0000_00FF, rd);
      run_op(i[0] ? 32'h0000_0004 : 32'h0000_0003);
      chk("suspend poll bit", rd[7], 1'b1);
      chk("suspend reads", reads, i[0] ? 16'h0003 : 16'h0002);
      chk("suspend no failure", st[2], 1'b0);
    end
    // Protected targets: busy for a while, then the old array comes back
    for (i = 0; i < 2; i++) begin
      ld_prot <= 1'b1;
      setup(i[0] ? M_ERASE : M_PROG, 8'h04, 8'hA5, 1'b0, 1'b0);
      run_op(32'h0000_0004);
      chk("protected array kept", rd, 32'h0000_0000);
      chk("protected no failure", st[2], 1'b0);
    end
    ld_prot <= 1'b0;
    complete_run;
  end
endmodule
`default_nettype wire
